//--- hdl/sitb_pkg.sv
package sitb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MODE   = 10'h0c0;
  localparam logic [9:0] IDX_SCR    = 10'h0c2;
  localparam logic [9:0] IDX_BAUD   = 10'h0c3;
  localparam logic [9:0] IDX_STAT   = 10'h0c8;
  localparam logic [9:0] IDX_MASK   = 10'h0c9;
  localparam int         ADDR_SHIFT = 2;
  // Mode register fields
  localparam int MODE_FMT_LSB = 0;   // 3 bits
  localparam int MODE_IO      = 3;   // 1: clocked shift mode
  localparam int MODE_SCLK_IN = 4;   // 1: external shift clock
  localparam int MODE_FALL    = 5;   // 1: falling edge mode
  // Serial control error flag positions
  localparam int SCR_OERR = 2;
  localparam int SCR_PERR = 3;
  localparam int SCR_FERR = 4;
  // Baud control fields
  localparam int        BR_DIV_LSB = 0;
  localparam int        BR_SRC_LSB = 4;
  localparam int        BR_FRAC    = 6;
  localparam logic [7:0] BR_WMASK  = 8'h7f;
  localparam logic [7:0] BR_RESET  = 8'h00;
  // Interrupt status bits
  localparam int ST_TX  = 0;
  localparam int ST_RX  = 1;
  localparam int ST_ERR = 2;
  localparam int IO_BITS = 8;
  // Frame formats
  typedef enum logic [2:0] {
    FMT_7     = 3'h0,
    FMT_7P    = 3'h1,
    FMT_8     = 3'h2,
    FMT_8P    = 3'h3,
    FMT_9     = 3'h4
  } sitb_fmt_type;
  // Event strobes from the serial engine
  typedef struct packed {
    logic tx_shift;
    logic rx_centre;
    logic io_start;
    logic err_over;
    logic err_par;
    logic err_frame;
  } sitb_evt_type;
endpackage

//--- hdl/sitb_ctrl.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Function
// - UART transmit interrupt raised just before the stop bit goes out.
// - Internal shift clock: transmit interrupt right after last rising edge.
// - External shift clock: transmit interrupt after last selected edge.
// - Shift mode receive interrupt when word moves to second buffer.
// - Reading serial control register clears all three error flags.
// - UART receive interrupt at ninth bit for 9-bit formats, else stop.
// - Data goes out LSB first; interrupt once transmit buffer empties.
module sitb_ctrl (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Serial engine events and shift clock pin
  input  wire sitb_pkg::sitb_evt_type evt,
  input  wire logic                  sclk_i,
  output logic                       sclk_o,
  output logic                       sclk_oe,
  // Interrupt timing outputs
  output logic                       transmit_done_irq,
  output logic                       receive_done_irq,
  output logic                       rx_transfer,
  output logic                       irq
);

  logic [5:0] mode_r;
  logic [7:0] baud_rate_control_r;
  logic [2:0] err_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] io_cnt_r;
  logic       io_busy_r;
  logic [2:0] sclk_sync_r;
  logic [7:0] pre_cnt_r;
  logic [3:0] div_cnt_r;
  logic       baud_tick_r;
  logic       acc;
  logic       rd_scr;
  logic [9:0] idx;
  logic [3:0] nbits;
  logic       io_mode;
  logic       ext_clk;
  logic       ext_edge;
  logic       int_rise;
  logic       io_last;
  logic       tx_ev;
  logic       rx_ev;

  // Data bits per frame, parity counted as a bit
  function automatic logic [3:0] data_bits(input logic [2:0] f);
    case (f)
      sitb_pkg::FMT_7:  data_bits = 4'h7;
      sitb_pkg::FMT_7P: data_bits = 4'h8;
      sitb_pkg::FMT_8:  data_bits = 4'h8;
      default:          data_bits = 4'h9;
    endcase
  endfunction
  // Decode and shared terms
  assign idx      = paddr[11:sitb_pkg::ADDR_SHIFT];
  assign acc      = psel && penable && pready;
  assign rd_scr   = psel && penable && !pready && !pwrite &&
                    idx == sitb_pkg::IDX_SCR;
  assign nbits    = data_bits(mode_r[sitb_pkg::MODE_FMT_LSB +: 3]);
  assign io_mode  = mode_r[sitb_pkg::MODE_IO];
  assign ext_clk  = mode_r[sitb_pkg::MODE_SCLK_IN];
  assign ext_edge = mode_r[sitb_pkg::MODE_FALL] ?
                    (sclk_sync_r[2] && !sclk_sync_r[1]) :
                    (!sclk_sync_r[2] && sclk_sync_r[1]);
  assign int_rise = baud_tick_r && !sclk_o;
  assign io_last  = io_busy_r && io_cnt_r == 4'(sitb_pkg::IO_BITS - 1) &&
                    (ext_clk ? ext_edge : int_rise);
  assign tx_ev    = io_mode ? io_last :
                    (evt.tx_shift && tx_cnt_r == nbits + 4'h1);
  assign rx_ev    = io_mode ? io_last : (evt.rx_centre &&
                    (nbits == 4'h9 ? rx_cnt_r == nbits
                                   : rx_cnt_r == nbits + 4'h1));

  // APB handshake, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        case (idx)
          sitb_pkg::IDX_MODE: prdata <= {26'h0, mode_r};
          sitb_pkg::IDX_SCR:  prdata <= {27'h0, err_r, 2'h0};
          sitb_pkg::IDX_BAUD: prdata <= {24'h0, baud_rate_control_r};
          sitb_pkg::IDX_STAT: prdata <= {29'h0, stat_r};
          sitb_pkg::IDX_MASK: prdata <= {29'h0, mask_r};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r              <= 6'h00;
      baud_rate_control_r <= sitb_pkg::BR_RESET;
      mask_r              <= 3'h0;
    end else if (acc && pwrite) begin
      if (idx == sitb_pkg::IDX_MODE) mode_r <= pwdata[5:0];
      if (idx == sitb_pkg::IDX_BAUD)
        baud_rate_control_r <= pwdata[7:0] & sitb_pkg::BR_WMASK;
      if (idx == sitb_pkg::IDX_MASK) mask_r <= pwdata[2:0];
    end
  end

  // Error flags; a new error wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 3'h0;
    end else begin
      err_r <= (rd_scr ? 3'h0 : err_r) |
               {evt.err_frame, evt.err_par, evt.err_over};
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= (stat_r & ~((acc && pwrite && idx == sitb_pkg::IDX_STAT) ?
                 pwdata[2:0] : 3'h0)) |
                {evt.err_over | evt.err_par | evt.err_frame, rx_ev, tx_ev};
    end
  end

  // Level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(stat_r & mask_r);
  end

  // UART transmit bit counter: start, data bits, then stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_cnt_r <= 4'h0;
    else if (io_mode) tx_cnt_r <= 4'h0;
    else if (evt.tx_shift)
      tx_cnt_r <= (tx_cnt_r == nbits + 4'h1) ? 4'h0 : tx_cnt_r + 4'h1;
  end

  // UART receive centre counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_cnt_r <= 4'h0;
    else if (io_mode) rx_cnt_r <= 4'h0;
    else if (evt.rx_centre)
      rx_cnt_r <= (rx_cnt_r == nbits + 4'h1) ? 4'h0 : rx_cnt_r + 4'h1;
  end

  // Shift clock pin synchroniser and history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_sync_r <= 3'h7; // Idle level, no false edge
    else sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
  end

  // Baud tick from prescaler and divide value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r   <= 8'h00;
      div_cnt_r   <= 4'h0;
      baud_tick_r <= 1'b0;
    end else begin
      baud_tick_r <= 1'b0;
      pre_cnt_r   <= pre_cnt_r + 8'h01;
      if (pre_cnt_r == 8'h00 ||
          baud_rate_control_r[sitb_pkg::BR_SRC_LSB +: 2] == 2'h0) begin
        div_cnt_r <= div_cnt_r + 4'h1;
        if (div_cnt_r + 4'h1 == baud_rate_control_r[3:0]) begin
          div_cnt_r   <= 4'h0;
          baud_tick_r <= 1'b1;
        end
      end
    end
  end

  // Shift word sequencer, LSB first, eight clocks per word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_busy_r <= 1'b0;
      io_cnt_r  <= 4'h0;
    end else if (!io_mode) begin
      io_busy_r <= 1'b0;
      io_cnt_r  <= 4'h0;
    end else if (evt.io_start && !io_busy_r) begin
      io_busy_r <= 1'b1;
      io_cnt_r  <= 4'h0;
    end else if (io_last) begin
      io_busy_r <= 1'b0;
    end else if (io_busy_r && (ext_clk ? ext_edge : int_rise)) begin
      io_cnt_r <= io_cnt_r + 4'h1;
    end
  end

  // Internal shift clock drive, idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_o  <= 1'b1;
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= io_mode && !ext_clk;
      if (!io_busy_r || ext_clk) sclk_o <= 1'b1;
      else if (baud_tick_r) sclk_o <= !sclk_o;
    end
  end

  // Interrupt pulses at the documented moments
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_done_irq <= 1'b0;
      receive_done_irq  <= 1'b0;
      rx_transfer       <= 1'b0;
    end else begin
      transmit_done_irq <= tx_ev;
      receive_done_irq  <= rx_ev;
      rx_transfer       <= io_mode && io_last;
    end
  end

  property p_tx_uart;
    @(posedge pclk) disable iff (!presetn)
    (!io_mode && evt.tx_shift && tx_cnt_r == nbits + 4'h1)
      |=> transmit_done_irq ##1 !transmit_done_irq;
  endproperty
  a_tx_uart: assert property (p_tx_uart)
    else $error("tx irq not at stop bit start");

  property p_tx_int;
    @(posedge pclk) disable iff (!presetn)
    (io_mode && !ext_clk && io_busy_r && int_rise &&
     io_cnt_r == 4'h7) |=> transmit_done_irq && !io_busy_r;
  endproperty
  a_tx_int: assert property (p_tx_int)
    else $error("tx irq missing after last internal rise");

  property p_tx_ext;
    @(posedge pclk) disable iff (!presetn)
    (io_mode && ext_clk && io_busy_r && ext_edge && io_cnt_r == 4'h7)
      |=> transmit_done_irq;
  endproperty
  a_tx_ext: assert property (p_tx_ext)
    else $error("tx irq missing after last external edge");

  property p_rx_io;
    @(posedge pclk) disable iff (!presetn)
    rx_transfer |-> receive_done_irq && transmit_done_irq;
  endproperty
  a_rx_io: assert property (p_rx_io)
    else $error("rx irq not with buffer transfer");

  property p_err_clr;
    @(posedge pclk) disable iff (!presetn)
    (rd_scr && !evt.err_over && !evt.err_par && !evt.err_frame)
      |=> err_r == 3'h0;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error flags not cleared by read");

  property p_rx_nine;
    @(posedge pclk) disable iff (!presetn)
    (!io_mode && nbits == 4'h9 && evt.rx_centre && rx_cnt_r == 4'h9)
      |=> receive_done_irq;
  endproperty
  a_rx_nine: assert property (p_rx_nine)
    else $error("rx irq not at ninth bit");

  property p_rx_stop;
    @(posedge pclk) disable iff (!presetn)
    (!io_mode && receive_done_irq && $past(nbits) != 4'h9)
      |-> $past(rx_cnt_r) == $past(nbits) + 4'h1;
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("rx irq not at stop centre");

  property p_baud_top;
    @(posedge pclk) disable iff (!presetn)
    (acc && pwrite && idx == sitb_pkg::IDX_BAUD)
      |=> baud_rate_control_r[7] == 1'b0 &&
          baud_rate_control_r[6:0] == $past(pwdata[6:0]);
  endproperty
  a_baud_top: assert property (p_baud_top)
    else $error("baud control write wrong");

endmodule // sitb_ctrl

//--- sim/sitb_peer.sv
`timescale 1ns/10ps
// Far side shift clock source for external clock mode
module sitb_peer (
  // Shift clock pin drive
  output logic    clk_drv,
  output logic    clk_oe,
  // Times of the last edges driven
  output realtime t_rise,
  output realtime t_fall
);
  // Line released, pull-up holds it high
  initial begin
    clk_drv = 1'b1;
    clk_oe  = 1'b0;
    t_rise  = 0;
    t_fall  = 0;
  end
  // Eight pulses at 125 ns; clock stands still between frames
  task automatic burst();
    #17 clk_oe = 1'b1;
    repeat (8) begin
      #62.5 clk_drv = 1'b0;
      t_fall = $realtime;
      #62.5 clk_drv = 1'b1;
      t_rise = $realtime;
    end
    #62.5 clk_oe = 1'b0;
  endtask
endmodule // sitb_peer

//--- sim/sitb_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module sitb_ctrl_tb;
  logic                   pclk, presetn, psel, penable, pwrite, pready;
  logic                   pslverr, sclk_o, sclk_oe, pdrv, poe, sclk_w;
  logic                   tdi, rdi, rxt, irq, err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd, v;
  logic [1:0]             pr;
  sitb_pkg::sitb_evt_type evt;
  realtime                tr, tf, tirq;
  int                     fails, check_count, seed, ntx, nrx, nrise, k, j, f;
  // Wire level of the shift clock pin
  assign sclk_w = sclk_oe ? sclk_o : (poe ? pdrv : 1'b1);
  sitb_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .transmit_done_irq(tdi), .receive_done_irq(rdi), .rx_transfer(rxt),
    .irq(irq));
  sitb_peer peer (.clk_drv(pdrv), .clk_oe(poe), .t_rise(tr), .t_fall(tf));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Count interrupt pulses and internal shift clock rises
  always @(posedge pclk) begin
    if (tdi === 1'b1) ntx++;
    if (rdi === 1'b1) nrx++;
  end
  always @(posedge sclk_o) nrise++;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin fails++; end_of_test(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One-cycle event pulse, then a random gap
  task automatic pulse(input sitb_pkg::sitb_evt_type e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
    repeat (3 + $unsigned($random(seed)) % 3) @(posedge pclk);
  endtask
  task automatic wait_tx();
    for (k = 0; k < 5000 && tdi !== 1'b1; k++) @(posedge pclk);
    if (tdi !== 1'b1) begin fails++; end_of_test(); end
    tirq = $realtime;
    // Buffer transfer and receive pulses stand only this cycle
    pr = {rxt, rdi};
  endtask
  // Pulse index of the stop bit and of the receive interrupt
  function automatic int stop_idx(int fm);
    return (fm == 0) ? 9 : (fm < 3) ? 10 : 11;
  endfunction
  function automatic int rx_idx(int fm);
    return (fm == 0) ? 9 : 10;
  endfunction
  // Error strobes to flag order overrun, parity, framing
  function automatic logic [2:0] err_exp(logic [5:0] e);
    return {e[0], e[1], e[2]};
  endfunction
  initial begin
    seed = 32'hed9e;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    evt = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, sitb_pkg::IDX_BAUD, 0); `CHK(rd, 32'h0)
    apb(1, sitb_pkg::IDX_BAUD, 32'hff);
    apb(0, sitb_pkg::IDX_BAUD, 0); `CHK(rd, 32'h7f)
    apb(0, 10'h3ff, 0); `CHK({err, rd}, 33'h100000000)
    // UART frames in every format, both directions at once
    for (f = 0; f < 5; f++) begin
      apb(1, sitb_pkg::IDX_MODE, f);
      ntx = 0;
      nrx = 0;
      for (j = 1; j <= stop_idx(f); j++) begin
        pulse(6'h30);
        `CHK(ntx, int'(j >= stop_idx(f)))
        `CHK(nrx, int'(j >= rx_idx(f)))
      end
      if (f == 0) begin
        apb(0, sitb_pkg::IDX_STAT, 0); `CHK(rd[1:0], 2'h3)
        `CHK(irq, 1'b0)
        apb(1, sitb_pkg::IDX_MASK, 7);
        repeat (2) @(posedge pclk); `CHK(irq, 1'b1)
        apb(1, sitb_pkg::IDX_STAT, 7);
        repeat (2) @(posedge pclk); `CHK(irq, 1'b0)
      end
    end
    $display("test uart done");
    // Shift mode, internal clock, random divide
    v = $unsigned($random(seed)) & 32'h4f;
    apb(1, sitb_pkg::IDX_BAUD, v);
    apb(0, sitb_pkg::IDX_BAUD, 0); `CHK(rd, v)
    apb(1, sitb_pkg::IDX_MODE, 8);
    nrise = 0;
    pulse(6'h08);
    wait_tx();
    `CHK(nrise, 8)
    `CHK(pr, 2'h3)
    `CHK(sclk_oe, 1'b1)
    // Shift mode, external clock, rising then falling
    for (f = 0; f < 2; f++) begin
      apb(1, sitb_pkg::IDX_MODE, 32'h18 | (f << 5));
      @(posedge pclk);
      evt <= 6'h08;
      @(posedge pclk);
      evt <= '0;
      fork
        peer.burst();
        wait_tx();
      join
      `CHK(pr, 2'h3)
      `CHK(sclk_oe, 1'b0)
      tirq = tirq - (f ? tf : tr);
      `CHK(tirq >= 1.0 && tirq <= 64.0, 1'b1)
    end
    $display("test shift done");
    // Error flags cleared together by one read
    pulse(6'h07);
    apb(0, sitb_pkg::IDX_SCR, 0); `CHK(rd[4:2], 3'h7)
    apb(0, sitb_pkg::IDX_SCR, 0); `CHK(rd[4:2], 3'h0)
    v = $unsigned($random(seed)) & 32'h7;
    pulse(v[5:0]);
    apb(0, sitb_pkg::IDX_SCR, 0); `CHK(rd[4:2], err_exp(v[5:0]))
    $display("test errors done");
    end_of_test();
  end
endmodule // sitb_ctrl_tb
